// [rtl/ecm_map.svh]
`ifndef ECM_MAP_SVH
`define ECM_MAP_SVH

// EEPROM word byte addresses, one 16-bit word each
`define ECM_EE_SIG   8'h00
`define ECM_EE_VID   8'h02
`define ECM_EE_DID   8'h04
`define ECM_EE_W06   8'h06
`define ECM_EE_SVID  8'h08
`define ECM_EE_SID   8'h0a
`define ECM_EE_W0C   8'h0c
`define ECM_EE_STEP  8'h02

// Configuration byte offsets, per port
`define ECM_OFF_ID   9'h000
`define ECM_OFF_INT  9'h03c
`define ECM_OFF_CDIS 9'h070
`define ECM_OFF_SWM  9'h074
`define ECM_OFF_ORD  9'h08c
`define ECM_OFF_SUB  9'h0b4
`define ECM_OFF_DCAP 9'h0c4
`define ECM_OFF_LCAP 9'h0cc
`define ECM_OFF_LTR  9'h0e4
`define ECM_OFF_EVC  9'h144

// Identifier halves and byte lanes
`define ECM_ID_LO    15:0
`define ECM_ID_HI    31:16
`define ECM_LANE_W   8

// Word 06h sources (E) and register targets (C)
`define ECM_E_VC     0
`define ECM_C_VC     0
`define ECM_E_L0S    3:1
`define ECM_C_L0S    14:12
`define ECM_E_L1     6:4
`define ECM_C_L1     17:15
`define ECM_E_NOEGR  8
`define ECM_C_NOEGR  5
`define ECM_E_NOTAG  9
`define ECM_C_NOTAG  6
`define ECM_E_SAF    10
`define ECM_C_SAF    0
`define ECM_E_CUT    12:11
`define ECM_C_CUT    2:1
`define ECM_E_ARB    13
`define ECM_C_ARB    3
`define ECM_E_CRED   14
`define ECM_C_CRED   4
`define ECM_E_INTA   15
`define ECM_C_INTA   8

// Word 0Ch sources (E) and register targets (C)
`define ECM_E_MPS    1:0
`define ECM_C_MPS    1:0
`define ECM_E_ASPM   3:2
`define ECM_C_ASPM   11:10
`define ECM_E_RBER   4
`define ECM_C_RBER   15
`define ECM_E_MSI    5
`define ECM_C_MSI    14
`define ECM_E_PAR    6
`define ECM_C_PAR    15
`define ECM_E_PM     7
`define ECM_C_PM     13
`define ECM_E_PPNP   8
`define ECM_C_PPNP   5
`define ECM_E_LBN    9
`define ECM_C_LBN    21
`define ECM_E_FRZ    10
`define ECM_C_FRZ    6
`define ECM_E_SOF    11
`define ECM_C_SOF    0
`define ECM_E_SD     12
`define ECM_C_SD     19
`define ECM_E_DSEL   13
`define ECM_C_DSEL   1
`define ECM_E_LTR    14
`define ECM_C_LTR    12
`define ECM_E_B4K    15
`define ECM_C_B4K    3

`endif

// [rtl/ecm_pkg.sv]
package ecm_pkg;

  localparam int ECM_NPORT = 3;
  localparam int ECM_NREG  = 10;

  // Register slots held per port
  typedef enum logic [3:0] {
    ECM_R_ID   = 4'h0,
    ECM_R_INT  = 4'h1,
    ECM_R_CDIS = 4'h2,
    ECM_R_SWM  = 4'h3,
    ECM_R_ORD  = 4'h4,
    ECM_R_SUB  = 4'h5,
    ECM_R_DCAP = 4'h6,
    ECM_R_LCAP = 4'h7,
    ECM_R_LTR  = 4'h8,
    ECM_R_EVC  = 4'h9
  } ecm_reg_t;

  // Loader states
  typedef enum logic [1:0] {
    ECM_ST_IDLE  = 2'b00,
    ECM_ST_FETCH = 2'b01,
    ECM_ST_APPLY = 2'b10,
    ECM_ST_DONE  = 2'b11
  } ecm_state_t;

endpackage

// [rtl/ecm_field_map.sv]
`timescale 1ns/1ps
`include "ecm_map.svh"

module ecm_field_map #(
  parameter int PORT = 0
) (
  // Loaded EEPROM words
  input  wire logic [15:0]                             w06,
  input  wire logic [15:0]                             w0c,
  // Bits to overwrite and their new values
  output logic      [ecm_pkg::ECM_NREG-1:0][31:0]      fmask,
  output logic      [ecm_pkg::ECM_NREG-1:0][31:0]      fval
);

  // Scatter the two words into register fields
  always_comb begin
    fmask = '0;
    fval  = '0;
    fmask[ecm_pkg::ECM_R_EVC][`ECM_C_VC]     = '1;
    fval[ecm_pkg::ECM_R_EVC][`ECM_C_VC]      = w06[`ECM_E_VC];
    fmask[ecm_pkg::ECM_R_LCAP][`ECM_C_L0S]   = '1;
    fval[ecm_pkg::ECM_R_LCAP][`ECM_C_L0S]    = w06[`ECM_E_L0S];
    fmask[ecm_pkg::ECM_R_LCAP][`ECM_C_L1]    = '1;
    fval[ecm_pkg::ECM_R_LCAP][`ECM_C_L1]     = w06[`ECM_E_L1];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_NOEGR]  = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_NOEGR]   = w06[`ECM_E_NOEGR];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_NOTAG]  = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_NOTAG]   = w06[`ECM_E_NOTAG];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_SAF]    = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_SAF]     = w06[`ECM_E_SAF];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_CUT]    = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_CUT]     = w06[`ECM_E_CUT];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_ARB]    = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_ARB]     = w06[`ECM_E_ARB];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_CRED]   = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_CRED]    = w06[`ECM_E_CRED];
    fmask[ecm_pkg::ECM_R_DCAP][`ECM_C_MPS]   = '1;
    fval[ecm_pkg::ECM_R_DCAP][`ECM_C_MPS]    = w0c[`ECM_E_MPS];
    fmask[ecm_pkg::ECM_R_LCAP][`ECM_C_ASPM]  = '1;
    fval[ecm_pkg::ECM_R_LCAP][`ECM_C_ASPM]   = w0c[`ECM_E_ASPM];
    fmask[ecm_pkg::ECM_R_DCAP][`ECM_C_RBER]  = '1;
    fval[ecm_pkg::ECM_R_DCAP][`ECM_C_RBER]   = w0c[`ECM_E_RBER];
    fmask[ecm_pkg::ECM_R_CDIS][`ECM_C_MSI]   = '1;
    fval[ecm_pkg::ECM_R_CDIS][`ECM_C_MSI]    = w0c[`ECM_E_MSI];
    fmask[ecm_pkg::ECM_R_CDIS][`ECM_C_PM]    = '1;
    fval[ecm_pkg::ECM_R_CDIS][`ECM_C_PM]     = w0c[`ECM_E_PM];
    fmask[ecm_pkg::ECM_R_SWM][`ECM_C_PAR]    = '1;
    fval[ecm_pkg::ECM_R_SWM][`ECM_C_PAR]     = w0c[`ECM_E_PAR];
    fmask[ecm_pkg::ECM_R_ORD][`ECM_C_PPNP]   = '1;
    fval[ecm_pkg::ECM_R_ORD][`ECM_C_PPNP]    = w0c[`ECM_E_PPNP];
    fmask[ecm_pkg::ECM_R_ORD][`ECM_C_FRZ]    = '1;
    fval[ecm_pkg::ECM_R_ORD][`ECM_C_FRZ]     = w0c[`ECM_E_FRZ];
    fmask[ecm_pkg::ECM_R_ORD][`ECM_C_SOF]    = '1;
    fval[ecm_pkg::ECM_R_ORD][`ECM_C_SOF]     = w0c[`ECM_E_SOF];
    fmask[ecm_pkg::ECM_R_LCAP][`ECM_C_SD]    = '1;
    fval[ecm_pkg::ECM_R_LCAP][`ECM_C_SD]     = w0c[`ECM_E_SD];
    fmask[ecm_pkg::ECM_R_ORD][`ECM_C_DSEL]   = '1;
    fval[ecm_pkg::ECM_R_ORD][`ECM_C_DSEL]    = w0c[`ECM_E_DSEL];
    fmask[ecm_pkg::ECM_R_LTR][`ECM_C_LTR]    = '1;
    fval[ecm_pkg::ECM_R_LTR][`ECM_C_LTR]     = w0c[`ECM_E_LTR];
    fmask[ecm_pkg::ECM_R_ORD][`ECM_C_B4K]    = '1;
    fval[ecm_pkg::ECM_R_ORD][`ECM_C_B4K]     = w0c[`ECM_E_B4K];
    // Downstream ports only
    if (PORT != 0) begin
      fmask[ecm_pkg::ECM_R_INT][`ECM_C_INTA] = '1;
      fval[ecm_pkg::ECM_R_INT][`ECM_C_INTA]  = w06[`ECM_E_INTA];
      fmask[ecm_pkg::ECM_R_LCAP][`ECM_C_LBN] = '1;
      fval[ecm_pkg::ECM_R_LCAP][`ECM_C_LBN]  = w0c[`ECM_E_LBN];
    end
  end

endmodule // ecm_field_map

// [rtl/ecm_loader.sv]
`timescale 1ns/1ps
`include "ecm_map.svh"

module ecm_loader #(
  parameter logic [15:0]       SIGNATURE   = 16'h5a5a, // Arbitrary value
  parameter int unsigned       ACK_TIMEOUT = 1024,
  parameter logic [ecm_pkg::ECM_NREG-1:0][31:0] REG_DEFAULT = '0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // EEPROM word read port
  output logic             ee_req,
  output logic [7:0]       ee_addr,
  input  wire logic        ee_ack,
  input  wire logic [15:0] ee_rdata,
  // Load control and status
  input  wire logic        reload,
  output logic             load_busy,
  output logic             load_done,
  output logic             sig_ok,
  output logic             sig_bad,
  output logic             ee_timeout,
  // Configuration access port
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [1:0]  cfg_port,
  input  wire logic [8:0]  cfg_offset,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ready,
  output logic             cfg_rvalid,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_err,
  // Per-port decoded controls, bit n for port n (cut_through_thr: bits 2n+1:2n)
  output logic [2:0]       store_forward_en,
  output logic [5:0]       cut_through_thr,
  output logic [2:0]       port_arb_mode,
  output logic [2:0]       credit_update_mode,
  output logic [2:0]       msi_cap_disable,
  output logic [2:0]       pm_cap_disable,
  output logic [2:0]       compliance_parity_disable,
  output logic [2:0]       posted_pass_nonposted_enable,
  output logic [2:0]       ordering_frozen,
  output logic [2:0]       tx_sof_latency_mode,
  output logic [2:0]       pm_data_select_writable,
  output logic [2:0]       boundary_4k_check_en,
  output logic [2:0]       ltr_cap_enable
);

  localparam int NP = ecm_pkg::ECM_NPORT;
  localparam int NR = ecm_pkg::ECM_NREG;
  localparam int CW = $clog2(ACK_TIMEOUT + 1);

  // Loader state
  ecm_pkg::ecm_state_t state;
  ecm_pkg::ecm_state_t next_state;
  logic [7:0]          ee_addr_q;
  logic [7:0]          next_addr;
  logic [CW-1:0]       wait_cnt;
  logic [CW-1:0]       next_cnt;
  logic [15:0]         w06;
  logic [15:0]         next_w06;
  logic [15:0]         w0c;
  logic [15:0]         next_w0c;
  logic [15:0]         vid;
  logic [15:0]         next_vid;
  logic [15:0]         did;
  logic [15:0]         next_did;
  logic [15:0]         svid;
  logic [15:0]         next_svid;
  logic [15:0]         sid;
  logic [15:0]         next_sid;
  logic                sig_ok_q;
  logic                next_sig_ok;
  logic                sig_bad_q;
  logic                next_sig_bad;
  logic                tmo_q;
  logic                next_tmo;

  // Register storage
  logic [31:0]         cfg_q    [NP][NR];
  logic [31:0]         next_cfg [NP][NR];
  logic [NR-1:0][31:0] fmask    [NP];
  logic [NR-1:0][31:0] fval     [NP];

  // Read answer
  logic                rvalid_q;
  logic                next_rvalid;
  logic [31:0]         rdata_q;
  logic [31:0]         next_rdata;
  logic                err_q;
  logic                next_err;

  // Access decode
  logic                take_rd;
  logic                take_wr;
  logic [4:0]          rd_dec;
  logic [4:0]          wr_dec;
  logic                port_ok;

  // Offset to slot: hit flag above slot index
  function automatic logic [4:0] reg_decode(input logic [8:0] off);
    case (off)
      `ECM_OFF_ID:   reg_decode = {1'b1, ecm_pkg::ECM_R_ID};
      `ECM_OFF_INT:  reg_decode = {1'b1, ecm_pkg::ECM_R_INT};
      `ECM_OFF_CDIS: reg_decode = {1'b1, ecm_pkg::ECM_R_CDIS};
      `ECM_OFF_SWM:  reg_decode = {1'b1, ecm_pkg::ECM_R_SWM};
      `ECM_OFF_ORD:  reg_decode = {1'b1, ecm_pkg::ECM_R_ORD};
      `ECM_OFF_SUB:  reg_decode = {1'b1, ecm_pkg::ECM_R_SUB};
      `ECM_OFF_DCAP: reg_decode = {1'b1, ecm_pkg::ECM_R_DCAP};
      `ECM_OFF_LCAP: reg_decode = {1'b1, ecm_pkg::ECM_R_LCAP};
      `ECM_OFF_LTR:  reg_decode = {1'b1, ecm_pkg::ECM_R_LTR};
      `ECM_OFF_EVC:  reg_decode = {1'b1, ecm_pkg::ECM_R_EVC};
      default:       reg_decode = '0;
    endcase
  endfunction

  // Slots that software may write
  function automatic logic reg_writable(input logic [3:0] idx);
    reg_writable = (idx == ecm_pkg::ECM_R_CDIS) || (idx == ecm_pkg::ECM_R_SWM) ||
                   (idx == ecm_pkg::ECM_R_ORD)  || (idx == ecm_pkg::ECM_R_LTR);
  endfunction

  // Loader handshake and status
  assign ee_req     = (state == ecm_pkg::ECM_ST_FETCH);
  assign ee_addr    = ee_addr_q;
  assign load_busy  = (state != ecm_pkg::ECM_ST_DONE);
  assign load_done  = (state == ecm_pkg::ECM_ST_DONE);
  assign sig_ok     = sig_ok_q;
  assign sig_bad    = sig_bad_q;
  assign ee_timeout = tmo_q;

  // Loader next state
  always_comb begin
    next_state   = state;
    next_addr    = ee_addr_q;
    next_cnt     = wait_cnt;
    next_w06     = w06;
    next_w0c     = w0c;
    next_vid     = vid;
    next_did     = did;
    next_svid    = svid;
    next_sid     = sid;
    next_sig_ok  = sig_ok_q;
    next_sig_bad = sig_bad_q;
    next_tmo     = tmo_q;
    unique case (state)
      ecm_pkg::ECM_ST_IDLE: begin
        next_state = ecm_pkg::ECM_ST_FETCH;
        next_addr  = `ECM_EE_SIG;
        next_cnt   = '0;
      end
      ecm_pkg::ECM_ST_FETCH: begin
        if (ee_ack) begin
          next_cnt = '0;
          // Capture word by its address
          case (ee_addr_q)
            `ECM_EE_SIG: begin
              next_sig_ok  = (ee_rdata == SIGNATURE);
              next_sig_bad = (ee_rdata != SIGNATURE);
            end
            `ECM_EE_VID:  next_vid  = ee_rdata;
            `ECM_EE_DID:  next_did  = ee_rdata;
            `ECM_EE_W06:  next_w06  = ee_rdata;
            `ECM_EE_SVID: next_svid = ee_rdata;
            `ECM_EE_SID:  next_sid  = ee_rdata;
            `ECM_EE_W0C:  next_w0c  = ee_rdata;
            default:      next_cnt  = '0;
          endcase
          // Mismatch stops the load with storage left unchanged
          if ((ee_addr_q == `ECM_EE_SIG) && (ee_rdata != SIGNATURE)) begin
            next_state = ecm_pkg::ECM_ST_DONE;
          end else if (ee_addr_q == `ECM_EE_W0C) begin
            next_state = ecm_pkg::ECM_ST_APPLY;
          end else begin
            next_addr = ee_addr_q + `ECM_EE_STEP;
          end
        end else if (wait_cnt == CW'(ACK_TIMEOUT - 1)) begin
          next_tmo   = 1'b1;
          next_state = ecm_pkg::ECM_ST_DONE;
        end else begin
          next_cnt = wait_cnt + 1'b1;
        end
      end
      ecm_pkg::ECM_ST_APPLY: begin
        next_state = ecm_pkg::ECM_ST_DONE;
      end
      ecm_pkg::ECM_ST_DONE: begin
        if (reload) begin
          next_state   = ecm_pkg::ECM_ST_FETCH;
          next_addr    = `ECM_EE_SIG;
          next_cnt     = '0;
          next_sig_ok  = 1'b0;
          next_sig_bad = 1'b0;
          next_tmo     = 1'b0;
        end
      end
    endcase
  end

  // Loader registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= ecm_pkg::ECM_ST_IDLE;
      ee_addr_q <= `ECM_EE_SIG;
      wait_cnt  <= '0;
      w06       <= '0;
      w0c       <= '0;
      vid       <= '0;
      did       <= '0;
      svid      <= '0;
      sid       <= '0;
      sig_ok_q  <= 1'b0;
      sig_bad_q <= 1'b0;
      tmo_q     <= 1'b0;
    end else begin
      state     <= next_state;
      ee_addr_q <= next_addr;
      wait_cnt  <= next_cnt;
      w06       <= next_w06;
      w0c       <= next_w0c;
      vid       <= next_vid;
      did       <= next_did;
      svid      <= next_svid;
      sid       <= next_sid;
      sig_ok_q  <= next_sig_ok;
      sig_bad_q <= next_sig_bad;
      tmo_q     <= next_tmo;
    end
  end

  // Field scatter per port
  generate
    for (genvar g = 0; g < NP; g++) begin : g_map
      ecm_field_map #(
        .PORT (g)
      ) u_map (
        .w06   (w06),
        .w0c   (w0c),
        .fmask (fmask[g]),
        .fval  (fval[g])
      );
    end
  endgenerate

  // Access is offered only once loading is over
  assign cfg_ready = (state == ecm_pkg::ECM_ST_DONE);
  assign take_rd   = cfg_ready && cfg_rd;
  assign take_wr   = cfg_ready && cfg_wr && !cfg_rd;
  assign port_ok   = (cfg_port < 2'(NP));
  assign rd_dec    = reg_decode(cfg_offset);
  assign wr_dec    = reg_decode(cfg_offset);

  // Storage next value: load merge, then software writes
  always_comb begin
    next_cfg = cfg_q;
    if (state == ecm_pkg::ECM_ST_APPLY) begin
      for (int p = 0; p < NP; p++) begin
        for (int r = 0; r < NR; r++) begin
          next_cfg[p][r] = (cfg_q[p][r] & ~fmask[p][r]) |
                           (fval[p][r] & fmask[p][r]);
        end
        next_cfg[p][ecm_pkg::ECM_R_ID]  = {did, vid};
        next_cfg[p][ecm_pkg::ECM_R_SUB] = {sid, svid};
      end
    end
    if (take_wr && port_ok && wr_dec[4] && reg_writable(wr_dec[3:0])) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_be[b]) begin
          next_cfg[cfg_port][wr_dec[3:0]][b*`ECM_LANE_W +: `ECM_LANE_W] =
            cfg_wdata[b*`ECM_LANE_W +: `ECM_LANE_W];
        end
      end
    end
  end

  // Storage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NP; p++) begin
        for (int r = 0; r < NR; r++) begin
          cfg_q[p][r] <= REG_DEFAULT[r];
        end
      end
    end else begin
      cfg_q <= next_cfg;
    end
  end

  // Read answer and error next value
  always_comb begin
    next_rvalid = take_rd;
    next_rdata  = '0;
    next_err    = 1'b0;
    if (take_rd) begin
      if (port_ok && rd_dec[4]) begin
        next_rdata = cfg_q[cfg_port][rd_dec[3:0]];
      end else begin
        next_err = 1'b1;
      end
    end else if (take_wr) begin
      next_err = !(port_ok && wr_dec[4] && reg_writable(wr_dec[3:0]));
    end
  end

  // Read answer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      err_q    <= 1'b0;
    end else begin
      rvalid_q <= next_rvalid;
      rdata_q  <= next_rdata;
      err_q    <= next_err;
    end
  end

  assign cfg_rvalid = rvalid_q;
  assign cfg_rdata  = rdata_q;
  assign cfg_err    = err_q;

  // Decoded per-port controls straight from storage
  generate
    for (genvar g = 0; g < NP; g++) begin : g_out
      assign store_forward_en[g]   = cfg_q[g][ecm_pkg::ECM_R_SWM][`ECM_C_SAF];
      assign cut_through_thr[2*g +: 2] = cfg_q[g][ecm_pkg::ECM_R_SWM][`ECM_C_CUT];
      assign port_arb_mode[g]      = cfg_q[g][ecm_pkg::ECM_R_SWM][`ECM_C_ARB];
      assign credit_update_mode[g] = cfg_q[g][ecm_pkg::ECM_R_SWM][`ECM_C_CRED];
      assign msi_cap_disable[g]    = cfg_q[g][ecm_pkg::ECM_R_CDIS][`ECM_C_MSI];
      assign pm_cap_disable[g]     = cfg_q[g][ecm_pkg::ECM_R_CDIS][`ECM_C_PM];
      assign compliance_parity_disable[g] =
        cfg_q[g][ecm_pkg::ECM_R_SWM][`ECM_C_PAR];
      assign posted_pass_nonposted_enable[g] =
        cfg_q[g][ecm_pkg::ECM_R_ORD][`ECM_C_PPNP];
      assign ordering_frozen[g]    = cfg_q[g][ecm_pkg::ECM_R_ORD][`ECM_C_FRZ];
      assign tx_sof_latency_mode[g] = cfg_q[g][ecm_pkg::ECM_R_ORD][`ECM_C_SOF];
      assign pm_data_select_writable[g] =
        cfg_q[g][ecm_pkg::ECM_R_ORD][`ECM_C_DSEL];
      assign boundary_4k_check_en[g] = cfg_q[g][ecm_pkg::ECM_R_ORD][`ECM_C_B4K];
      assign ltr_cap_enable[g]     = cfg_q[g][ecm_pkg::ECM_R_LTR][`ECM_C_LTR];
    end
  endgenerate

endmodule // ecm_loader

// [tb/ecm_loader_monitor.sv]
`timescale 1ns/1ps
module ecm_loader_monitor #(
  parameter logic [15:0] SIGNATURE   = 16'h5a5a,
  parameter int unsigned ACK_TIMEOUT = 1024
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Word read port
  input wire logic        ee_req,
  input wire logic [7:0]  ee_addr,
  input wire logic        ee_ack,
  input wire logic [15:0] ee_rdata,
  // Load status
  input wire logic        load_done,
  input wire logic        sig_ok,
  input wire logic        sig_bad,
  input wire logic        ee_timeout,
  // Config port
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic        cfg_ready,
  input wire logic        cfg_rvalid,
  input wire logic        cfg_err,
  // Decoded controls
  input wire logic [2:0]  store_forward_en,
  input wire logic [5:0]  cut_through_thr,
  input wire logic [2:0]  posted_pass_nonposted_enable,
  input wire logic [2:0]  ltr_cap_enable
);
  localparam int unsigned LIM = ACK_TIMEOUT + 1;
  logic [15:0] c06;
  logic [15:0] c0c;
  logic [31:0] wcnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Words as fetched, and cycles of unanswered request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c06  <= 16'h0;
      c0c  <= 16'h0;
      wcnt <= 32'h0;
    end else begin
      if (ee_req && ee_ack && ee_addr == 8'h06) c06 <= ee_rdata;
      if (ee_req && ee_ack && ee_addr == 8'h0c) c0c <= ee_rdata;
      wcnt <= (ee_req && !ee_ack) ? wcnt + 32'h1 : 32'h0;
    end
  end
  sequence s_last; ee_req && ee_ack && ee_addr == 8'h0c; endsequence
  sequence s_fin; !ee_req ##1 (load_done && sig_ok); endsequence
  property p_ready; $rose(cfg_ready) |-> sig_ok || sig_bad || ee_timeout; endproperty
  a_ready: assert property (p_ready) else $error("ready without verdict");
  property p_read; cfg_ready && cfg_rd |=> cfg_rvalid; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_drop; !(cfg_ready && (cfg_rd || cfg_wr)) |=> !cfg_rvalid && !cfg_err; endproperty
  a_drop: assert property (p_drop) else $error("answer without request");
  property p_hold; ee_req && !ee_ack |=> !ee_req || $stable(ee_addr); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_step; ee_req && ee_ack && ee_addr != 8'h00 && ee_addr != 8'h0c
    |=> ee_req && ee_addr == $past(ee_addr) + 8'h02; endproperty
  a_step: assert property (p_step) else $error("bad address step");
  property p_sig; ee_req && ee_ack && ee_addr == 8'h00 && ee_rdata != SIGNATURE
    |-> ##[1:2] (sig_bad && load_done && !ee_req); endproperty
  a_sig: assert property (p_sig) else $error("mismatch not ended");
  property p_fin; s_last |=> s_fin; endproperty
  a_fin: assert property (p_fin) else $error("load not finished");
  property p_tmo; wcnt <= LIM; endproperty
  a_tmo: assert property (p_tmo) else $error("request waits too long");
  property p_f06; $rose(load_done) && sig_ok && !ee_timeout
    |-> store_forward_en == {3{c06[10]}} && cut_through_thr == {3{c06[12:11]}}; endproperty
  a_f06: assert property (p_f06) else $error("switch mode wrong");
  property p_f0c; $rose(load_done) && sig_ok && !ee_timeout
    |-> posted_pass_nonposted_enable == {3{c0c[8]}} && ltr_cap_enable == {3{c0c[14]}};
  endproperty
  a_f0c: assert property (p_f0c) else $error("word 0c fields wrong");
endmodule // ecm_loader_monitor

bind ecm_loader ecm_loader_monitor #(.SIGNATURE(SIGNATURE), .ACK_TIMEOUT(ACK_TIMEOUT)) u_mon (
  .clk, .rst, .ee_req, .ee_addr, .ee_ack, .ee_rdata, .load_done, .sig_ok, .sig_bad,
  .ee_timeout, .cfg_rd, .cfg_wr, .cfg_ready, .cfg_rvalid, .cfg_err, .store_forward_en,
  .cut_through_thr, .posted_pass_nonposted_enable, .ltr_cap_enable
);

// [tb/ecm_eeprom_model.sv]
`timescale 1ns/1ps
module ecm_eeprom_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Word read port
  input  wire logic             ee_req,
  input  wire logic [7:0]       ee_addr,
  output logic                  ee_ack,
  output logic [15:0]           ee_rdata,
  // Image, answer delay, silence
  input  wire logic [6:0][15:0] img,
  input  wire logic [3:0]       lag,
  input  wire logic             mute
);
  logic [15:0] q;
  logic [3:0]  wt;
  // Signature at word zero, data words at even addresses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ee_ack <= 1'b0;
      q      <= 16'h0;
      wt     <= 4'h0;
    end else begin
      ee_ack <= 1'b0;
      if (ee_req && !ee_ack && !mute) begin
        if (wt >= lag) begin
          ee_ack <= 1'b1;
          q      <= img[ee_addr[3:1]];
          wt     <= 4'h0;
        end else begin
          wt <= wt + 4'h1;
        end
      end
    end
  end
  // Data is valid only in the acknowledge cycle
  assign ee_rdata = ee_ack ? q : ~q;
endmodule // ecm_eeprom_model

// [tb/test_eeprom_config_word_mapper.sv]
`timescale 1ns/1ps
module test_eeprom_config_word_mapper;
  localparam logic [15:0] SIG = 16'h5a5a; // Arbitrary signature
  localparam logic [15:0] VID = 16'h1a2b; // Arbitrary identifiers
  localparam logic [15:0] DID = 16'h3c4d;
  localparam logic [15:0] SVID = 16'h5e6f;
  localparam logic [15:0] SID = 16'h7081;
  logic        clk, ee_req, ee_ack, load_done, sig_ok, sig_bad, ee_timeout;
  logic        cfg_ready, cfg_rvalid, cfg_err;
  logic        rst = 1'b1, reload = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, mute = 1'b0;
  logic [1:0]  cfg_port = 2'h0;
  logic [3:0]  cfg_be = 4'h0, lag = 4'h0;
  logic [8:0]  cfg_offset = 9'h000;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [15:0] sg = SIG, w06 = 16'h3a5c, w0c = 16'hc5a3, ld06 = 16'h3a5c, ld0c = 16'hc5a3;
  logic [15:0] ee_rdata;
  logic [7:0]  ee_addr;
  logic [2:0]  store_forward_en, posted_pass_nonposted_enable, ltr_cap_enable;
  logic [5:0]  cut_through_thr;
  logic [26:0] ctl;
  int          bad_count = 0, n_tests = 0;
  logic [8:0]  offs [10] = '{9'h000, 9'h03c, 9'h070, 9'h074, 9'h08c, 9'h0b4,
                             9'h0c4, 9'h0cc, 9'h0e4, 9'h144};
  // Device and its image source
  ecm_loader #(.SIGNATURE(SIG), .ACK_TIMEOUT(8)) i_dut (
    .clk, .rst, .ee_req, .ee_addr, .ee_ack, .ee_rdata, .reload, .load_busy(), .load_done,
    .sig_ok, .sig_bad, .ee_timeout, .cfg_rd, .cfg_wr, .cfg_port, .cfg_offset, .cfg_be,
    .cfg_wdata, .cfg_ready, .cfg_rvalid, .cfg_rdata, .cfg_err, .store_forward_en,
    .cut_through_thr, .port_arb_mode(ctl[2:0]), .credit_update_mode(ctl[5:3]),
    .msi_cap_disable(ctl[8:6]), .pm_cap_disable(ctl[11:9]),
    .compliance_parity_disable(ctl[14:12]), .posted_pass_nonposted_enable,
    .ordering_frozen(ctl[17:15]), .tx_sof_latency_mode(ctl[20:18]),
    .pm_data_select_writable(ctl[23:21]), .boundary_4k_check_en(ctl[26:24]), .ltr_cap_enable);
  ecm_eeprom_model u_rom (.clk, .rst, .ee_req, .ee_addr, .ee_ack, .ee_rdata,
    .img({w0c, SID, SVID, w06, DID, VID, sg}), .lag, .mute);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Expected register word from the last good image
  function automatic logic [31:0] exp_reg(input int p, input logic [8:0] off);
    logic [31:0] r;
    r = 32'h0;
    case (off)
      9'h000: r = {DID, VID};
      9'h0b4: r = {SID, SVID};
      9'h144: r[0] = ld06[0];
      9'h03c: r[8] = (p > 0) & ld06[15];
      9'h074: r[15:0] = {ld0c[6], 8'h00, ld06[9:8], ld06[14:10]};
      9'h0c4: r[15:0] = {ld0c[4], 13'h0, ld0c[1:0]};
      9'h070: r[14:13] = {ld0c[5], ld0c[7]};
      9'h08c: r[6:0] = {ld0c[10], ld0c[8], 1'b0, ld0c[15], 1'b0, ld0c[13], ld0c[11]};
      9'h0cc: r[21:10] = {(p > 0) & ld0c[9], 1'b0, ld0c[12], 1'b0, ld06[6:1], ld0c[3:2]};
      9'h0e4: r[12] = ld0c[14];
      default: r = 32'h0;
    endcase
    return r;
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // One configuration access, answer sampled one cycle later
  task automatic cfg_rw(input logic wr, input logic [1:0] p, input logic [8:0] off,
                        input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    #1;
    {cfg_rd, cfg_wr, cfg_port, cfg_offset, cfg_be, cfg_wdata} = {!wr, wr, p, off, be, d};
    @(posedge clk);
    #1;
    {cfg_rd, cfg_wr} = 2'b00;
    q = cfg_rdata;
    if (!wr) chk(cfg_rvalid, 1);
  endtask
  // Bounded wait for load completion
  task automatic wait_done;
    for (int i = 0; i < 500 && load_done !== 1'b1; i++) @(posedge clk) #1;
    chk(load_done, 1);
  endtask
  // Every register of every port, and decoded controls
  task automatic chk_all;
    logic [31:0] q;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 10; k++) begin
        cfg_rw(1'b0, p[1:0], offs[k], 4'h0, 32'h0, q);
        chk(q, exp_reg(p, offs[k]));
      end
    end
    chk(store_forward_en, {3{ld06[10]}});
    chk(cut_through_thr, {3{ld06[12:11]}});
    chk(posted_pass_nonposted_enable, {3{ld0c[8]}});
    chk(ltr_cap_enable, {3{ld0c[14]}});
    chk(ctl, {{3{ld0c[15]}}, {3{ld0c[13]}}, {3{ld0c[11]}}, {3{ld0c[10]}},
      {3{ld0c[6]}}, {3{ld0c[7]}}, {3{ld0c[5]}}, {3{ld06[14]}}, {3{ld06[13]}}});
  endtask
  // Reload with a new image and judge the outcome
  task automatic t_load(input logic [15:0] s, a, b, input logic good, bad);
    @(posedge clk);
    #1;
    {sg, w06, w0c, reload} = {s, a, b, 1'b1};
    @(posedge clk);
    #1;
    reload = 1'b0;
    wait_done();
    chk(sig_ok, good);
    chk(sig_bad, bad);
    chk(ee_timeout, mute);
    if (good) {ld06, ld0c} = {a, b};
    chk_all();
  endtask
  // Refused accesses
  task automatic t_err;
    logic [31:0] q;
    cfg_rw(1'b1, 2'd1, 9'h0c4, 4'hf, 32'hffffffff, q);
    chk(cfg_err, 1);
    cfg_rw(1'b0, 2'd0, 9'h010, 4'h0, 32'h0, q);
    chk(cfg_err, 1);
    chk(q, 32'h0);
    cfg_rw(1'b0, 2'd3, 9'h074, 4'h0, 32'h0, q);
    chk(cfg_err, 1);
  endtask
  // Byte-enabled write reaches register and controls
  task automatic t_wr;
    logic [31:0] q;
    cfg_rw(1'b1, 2'd2, 9'h074, 4'h1, 32'hffffff7f, q);
    chk({store_forward_en, cut_through_thr}, {1'b1, {2{ld06[10]}}, 2'b11, {2{ld06[12:11]}}});
    cfg_rw(1'b0, 2'd2, 9'h074, 4'h0, 32'h0, q);
    chk(q, exp_reg(2, 9'h074) | 32'h7f);
  endtask
  // Verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    wait_done();
    chk(sig_ok, 1);
    chk_all();
    t_err();
    t_wr();
    lag = 4'h3;
    t_load(SIG, 16'hc5a3, 16'h3a5c, 1'b1, 1'b0);
    t_load(~SIG, 16'hffff, 16'hffff, 1'b0, 1'b1);
    mute = 1'b1;
    t_load(SIG, 16'h0000, 16'h0000, 1'b0, 1'b0);
    summarize();
  end
endmodule // test_eeprom_config_word_mapper
